// file: design/cmd_param_mem.sv
`include "flash_region_protect_bits_defines.svh"
module cmd_param_mem (
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  input  wire logic        wr_i,
  input  wire logic [3:0]  idx_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  output logic      [95:0] bytes_o
);
  logic [7:0]  mem_reg  [12];
  logic [7:0]  mem_next [12];
  logic [31:0] rd_reg;
  logic [31:0] rd_next;

  // Big endian: lane 3 of the word holds the lowest byte number
  always_comb begin
    rd_next = rd_reg;
    for (int k = 0; k < 12; k++) begin
      mem_next[k] = mem_reg[k];
    end
    for (int j = 0; j < 4; j++) begin
      if (32'(idx_i) + 32'(j) < 12) begin
        if (wr_i && be_i[3-j]) begin
          mem_next[idx_i+4'(j)] = wdata_i[8*(3-j) +: 8];
        end
        rd_next[8*(3-j) +: 8] = mem_reg[idx_i+4'(j)];
      end else begin
        rd_next[8*(3-j) +: 8] = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_reg <= 32'h0;
      for (int k = 0; k < 12; k++) begin
        mem_reg[k] <= 8'h00;
      end
    end else if (ce_i) begin
      rd_reg <= rd_next;
      mem_reg <= mem_next;
    end
  end

  assign rdata_o = rd_reg;
  always_comb begin
    for (int k = 0; k < 12; k++) begin
      bytes_o[8*(11-k) +: 8] = mem_reg[k];
    end
  end
endmodule

// file: design/flash_region_protect_bits_defines.svh
`ifndef FLASH_REGION_PROTECT_BITS_DEFINES_SVH
`define FLASH_REGION_PROTECT_BITS_DEFINES_SVH
`define REGION_PROTECT_BITS_OFS_BASE      8'h10
`define REGION_PROTECT_BITS_OFS_LAST      8'h13
`define CMD_OFS_BASE       8'h04
`define CMD_OFS_LAST       8'h0f
`define CFG_OFS_REGION_PROTECT_BITS_HI    4'hb
`define CFG_OFS_REGION_PROTECT_BITS_LO    4'h8
`define REGION_PROTECT_BITS_RESET_VAL     32'hffffffff
`define SMALL_FLASH_KB     16'h0020
`define REGION_SHIFT_SMALL 5'h0a
`define UNUSED_HI_KB       16'h0018
`define UNUSED_B2_KB       16'h0010
`define UNUSED_B1_KB       16'h0008
`define CMD_ERASE_BLOCK    8'h08
`define CMD_ERASE_SECTOR   8'h09
`define CMD_PROGRAM_WORD   8'h06
`define CMD_ERASE_ALL      8'h44
`endif

// file: design/flash_region_protect_bits_pkg.sv
package flash_region_protect_bits_pkg;
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD} access_size_e;
  typedef struct packed {
    logic         valid;
    logic         write;
    logic [7:0]   offset;
    access_size_e size;
    logic [31:0]  wdata;
  } reg_req_s;
  typedef struct packed {
    logic        start;
    logic [7:0]  code;
    logic [23:0] addr;
  } cmd_s;
endpackage

// file: design/flash_region_protection.sv
`include "flash_region_protect_bits_defines.svh"
// Functional notes
// - Parameter bytes big endian, MSB lowest number
// - Parameter access as byte, halfword, word
// - Block program/erase in protected regions
// - 32 bits; 1 KB regions below 32 KB
// - High protect bytes unused for small flash
// - Bits 31..24 first register, 7..0 last
// - Reset loads registers from configuration bytes
// - Normal mode accepts only 1-to-0 writes
// - Special mode writes bits freely
// - Protected alteration sets violation flag
// - Block erase refused if any protected
// - Zero protects, one unprotects
// - Writing one launches, locks parameters
// - Two modes selected at chip level
module flash_region_protection (
  input  wire logic                      clk_sys_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      ce_i,
  input  wire flash_region_protect_bits_pkg::reg_req_s  req_i,
  input  wire logic                      stat_wr_i,
  input  wire logic [7:0]                stat_wdata_i,
  input  wire logic                      special_mode_i,
  input  wire logic [15:0]               flash_kb_i,
  input  wire logic                      cfg_valid_i,
  input  wire logic [31:0]               cfg_region_protect_bits_i,
  input  wire logic                      cmd_done_i,
  output logic [31:0]                    rdata_o,
  output logic                           command_complete_flag_o,
  output logic                           protection_violation_flag_o,
  output logic                           cmd_allowed_o,
  output logic [31:0]                    region_protect_bits_o,
  output flash_region_protect_bits_pkg::cmd_s           cmd_o
);
  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_CHECK, ST_BUSY} state_e;
  state_e      st_reg, st_next;
  logic [31:0] region_protect_bits_reg, region_protect_bits_next;
  logic        command_complete_flag_reg, command_complete_flag_next;
  logic        viol_reg, viol_next;
  logic        allow_reg, allow_next;
  logic [31:0] region_protect_bits_rd_reg, region_protect_bits_rd_next;
  logic        sel_region_protect_bits_reg, sel_region_protect_bits_next;
  logic [95:0] cmd_bytes;
  logic [31:0] mem_rdata;
  logic [3:0]  be;
  logic        in_cmd, in_region_protect_bits, size_ok;
  logic [7:0]  code;
  logic [23:0] addr;
  logic [4:0]  shift;
  logic [4:0]  idx;
  logic        hit, any_region_protect_bits;
  logic [31:0] used_mask;

  always_comb begin
    case (req_i.size)
      flash_region_protect_bits_pkg::SZ_BYTE: be = 4'b1000;
      flash_region_protect_bits_pkg::SZ_HALF: be = 4'b1100;
      flash_region_protect_bits_pkg::SZ_WORD: be = 4'b1111;
      default:                 be = 4'b0000;
    endcase
    case (req_i.size)
      flash_region_protect_bits_pkg::SZ_HALF: size_ok = ~req_i.offset[0];
      flash_region_protect_bits_pkg::SZ_WORD: size_ok = req_i.offset[1:0] == 2'b00;
      default:                 size_ok = 1'b1;
    endcase
  end
  assign in_cmd  = req_i.offset >= `CMD_OFS_BASE &&
                   req_i.offset <= `CMD_OFS_LAST && size_ok;
  assign in_region_protect_bits = req_i.offset >= `REGION_PROTECT_BITS_OFS_BASE &&
                   req_i.offset <= `REGION_PROTECT_BITS_OFS_LAST && size_ok;

  // Parameter writes ignored while a command runs
  cmd_param_mem u_mem (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .wr_i      (req_i.valid && req_i.write && in_cmd && command_complete_flag_reg),
    .idx_i     (4'(req_i.offset - `CMD_OFS_BASE)),
    .be_i      (be),
    .wdata_i   (req_i.wdata),
    .rdata_o   (mem_rdata),
    .bytes_o   (cmd_bytes)
  );

  assign code = cmd_bytes[95:88];
  assign addr = cmd_bytes[87:64];

  // Small parts use fixed 1 KB regions, else flash/32
  always_comb begin
    shift = `REGION_SHIFT_SMALL;
    if (flash_kb_i >= `SMALL_FLASH_KB) begin
      shift = 5'h05;
      for (int b = 0; b < 16; b++) begin
        if (flash_kb_i[b]) shift = 5'(b + 5);
      end
    end
    idx = 5'(addr >> shift);
    // Bytes above the flash size are not used
    used_mask = 32'hffffffff;
    if (flash_kb_i <= `UNUSED_HI_KB) used_mask[31:24] = 8'h00;
    if (flash_kb_i <= `UNUSED_B2_KB) used_mask[23:16] = 8'h00;
    if (flash_kb_i <= `UNUSED_B1_KB) used_mask[15:8]  = 8'h00;
    hit      = ~region_protect_bits_reg[idx] & used_mask[idx];
    any_region_protect_bits = |(~region_protect_bits_reg & used_mask);
  end

  always_comb begin
    int r;
    r            = 0;
    st_next      = st_reg;
    region_protect_bits_next    = region_protect_bits_reg;
    command_complete_flag_next    = command_complete_flag_reg;
    viol_next    = viol_reg;
    allow_next   = 1'b0;
    region_protect_bits_rd_next = region_protect_bits_rd_reg;
    sel_region_protect_bits_next = in_region_protect_bits;
    for (int j = 0; j < 4; j++) begin
      region_protect_bits_rd_next[8*(3-j) +: 8] =
        (32'(req_i.offset) + 32'(j) <= 32'(`REGION_PROTECT_BITS_OFS_LAST)) ?
        region_protect_bits_reg[8*(3 - 32'(req_i.offset[1:0]) - j) +: 8] : 8'h00;
    end
    if (req_i.valid && req_i.write && in_region_protect_bits) begin
      for (int j = 0; j < 4; j++) begin
        if (be[3-j] && 32'(req_i.offset[1:0]) + 32'(j) < 4) begin
          r = 3 - 32'(req_i.offset[1:0]) - j;
          if (special_mode_i) begin
            region_protect_bits_next[8*r +: 8] = req_i.wdata[8*(3-j) +: 8];
          end else begin
            region_protect_bits_next[8*r +: 8] = region_protect_bits_reg[8*r +: 8] &
                                  req_i.wdata[8*(3-j) +: 8];
          end
        end
      end
    end
    if (stat_wr_i && stat_wdata_i[4]) viol_next = 1'b0;
    case (st_reg)
      ST_LOAD: begin
        if (cfg_valid_i) begin
          region_protect_bits_next = cfg_region_protect_bits_i;
          st_next   = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // Pending violation blocks the launch
        if (stat_wr_i && stat_wdata_i[7] && !viol_reg) begin
          command_complete_flag_next = 1'b0;
          st_next   = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if ((code == `CMD_PROGRAM_WORD || code == `CMD_ERASE_SECTOR) && hit
            || (code == `CMD_ERASE_BLOCK || code == `CMD_ERASE_ALL)
               && any_region_protect_bits) begin
          viol_next = 1'b1;
          command_complete_flag_next = 1'b1;
          st_next   = ST_IDLE;
        end else begin
          allow_next = 1'b1;
          st_next    = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (cmd_done_i) begin
          command_complete_flag_next = 1'b1;
          st_next   = ST_IDLE;
        end
      end
      default: st_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg       <= ST_LOAD;
      region_protect_bits_reg     <= `REGION_PROTECT_BITS_RESET_VAL;
      command_complete_flag_reg     <= 1'b1;
      viol_reg     <= 1'b0;
      allow_reg    <= 1'b0;
      region_protect_bits_rd_reg  <= 32'h0;
      sel_region_protect_bits_reg <= 1'b0;
    end else if (ce_i) begin
      st_reg       <= st_next;
      region_protect_bits_reg     <= region_protect_bits_next;
      command_complete_flag_reg     <= command_complete_flag_next;
      viol_reg     <= viol_next;
      allow_reg    <= allow_next;
      region_protect_bits_rd_reg  <= region_protect_bits_rd_next;
      sel_region_protect_bits_reg <= sel_region_protect_bits_next;
    end
  end

  assign rdata_o = sel_region_protect_bits_reg ? region_protect_bits_rd_reg : mem_rdata;
  assign command_complete_flag_o     = command_complete_flag_reg;
  assign protection_violation_flag_o = viol_reg;
  assign cmd_allowed_o               = allow_reg;
  assign region_protect_bits_o       = region_protect_bits_reg;
  assign cmd_o = '{start: allow_reg, code: code, addr: addr};

  AST_NORMAL_NO_UNPROTECT: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    ce_i && !special_mode_i && st_reg != ST_LOAD
    |=> (region_protect_bits_reg & ~$past(region_protect_bits_reg)) == 32'h0)
    else $error("protection bit unprotected in normal mode");
  sequence s_launch;
    st_reg == ST_CHECK && ce_i;
  endsequence
  AST_VIOL_NO_START: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    s_launch ##1 viol_reg && !$past(viol_reg) |-> !allow_reg)
    else $error("command started despite violation");
  AST_BUSY_LOCK: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    !command_complete_flag_reg |=> $stable(cmd_bytes))
    else $error("parameters changed while busy");
  AST_COMMAND_COMPLETE_FLAG_BACK: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    s_launch ##1 viol_reg |-> command_complete_flag_reg)
    else $error("violation without completion");
  sequence s_block_erase_check;
    st_reg == ST_CHECK && ce_i &&
    (code == `CMD_ERASE_BLOCK || code == `CMD_ERASE_ALL) && any_region_protect_bits;
  endsequence
  AST_BLOCK_ERASE_REFUSED: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    s_block_erase_check |=> viol_reg && !allow_reg && command_complete_flag_reg)
    else $error("block erase ran over a protected region");
  AST_RESET_LOAD: assert property (
    @(posedge clk_sys_i) disable iff (!reset_n_i)
    st_reg == ST_LOAD && cfg_valid_i && ce_i
    |=> region_protect_bits_reg == $past(cfg_region_protect_bits_i))
    else $error("protection not loaded from configuration");
endmodule

// file: verif/cpu_bus_model.sv
module cpu_bus_model (
  input  wire logic                clk_sys_i,
  input  wire logic                flag_i,
  output flash_region_protect_bits_pkg::reg_req_s req_o,
  output logic                     stat_wr_o,
  output logic [7:0]               stat_wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_o = '0;
    stat_wr_o = 1'b0;
    stat_wdata_o = 8'h00;
  end
  // Released lines show inverted data so stale values never pass
  task automatic xfer(input logic w, input logic [7:0] o,
      input flash_region_protect_bits_pkg::access_size_e s, input logic [31:0] d);
    if (w && o >= 8'h10) wait (flag_i === 1'b1);
    @(posedge clk_sys_i);
    req_o <= '{valid: 1'b1, write: w, offset: o, size: s, wdata: d};
    @(posedge clk_sys_i);
    req_o <= '{valid: 1'b0, write: 1'b0, offset: ~o, size: s, wdata: ~d};
    #1;
  endtask
  task automatic st(input logic [7:0] d);
    @(posedge clk_sys_i);
    stat_wr_o <= 1'b1;
    stat_wdata_o <= d;
    @(posedge clk_sys_i);
    stat_wr_o <= 1'b0;
    stat_wdata_o <= ~d;
  endtask
endmodule

// file: verif/flash_region_protection_tb_top.sv
`define CMP(a, b) begin num_checks++; if ((a) !== (b)) begin \
  miscompares++; $display("unexpected at %0t: got %h exp %h", \
  $time, a, b); end end
module flash_region_protection_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam flash_region_protect_bits_pkg::access_size_e sz_w = flash_region_protect_bits_pkg::SZ_WORD;
  localparam flash_region_protect_bits_pkg::access_size_e sz_h = flash_region_protect_bits_pkg::SZ_HALF;
  logic                     clk_sys_i;
  logic                     reset_n_i;
  logic                     ce;
  logic                     special_mode_i;
  logic                     cfg_valid_i;
  logic                     cmd_done_i;
  logic [15:0]              flash_kb_i;
  logic [31:0]              cfg_region_protect_bits_i;
  logic [31:0]              rdata;
  logic [31:0]              bits;
  logic                     flag;
  logic                     viol;
  logic                     ok;
  logic                     stat_wr;
  logic [7:0]               stat_wdata;
  flash_region_protect_bits_pkg::reg_req_s req;
  flash_region_protect_bits_pkg::cmd_s     cmd;
  int                       miscompares = 0;
  int                       num_checks = 0;

  flash_region_protection dut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .ce_i(ce),
    .req_i(req), .stat_wr_i(stat_wr), .stat_wdata_i(stat_wdata),
    .special_mode_i(special_mode_i), .flash_kb_i(flash_kb_i),
    .cfg_valid_i(cfg_valid_i), .cfg_region_protect_bits_i(cfg_region_protect_bits_i),
    .cmd_done_i(cmd_done_i), .rdata_o(rdata),
    .command_complete_flag_o(flag), .protection_violation_flag_o(viol),
    .cmd_allowed_o(ok), .region_protect_bits_o(bits), .cmd_o(cmd)
  );
  cpu_bus_model cpu (
    .clk_sys_i(clk_sys_i), .flag_i(flag), .req_o(req),
    .stat_wr_o(stat_wr), .stat_wdata_o(stat_wdata)
  );

  task automatic results();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Loads parameters, launches, and follows the check to its outcome
  task automatic launch(input logic [7:0] c, input logic [23:0] a,
      input logic pass);
    int n;
    cpu.xfer(1'b1, 8'h04, sz_w, {c, a});
    cpu.st(8'h80);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
      n++;
    end while (!(viol === 1'b1 || ok === 1'b1) && n < 8);
    `CMP(ok, pass)
    `CMP(viol, !pass)
    if (pass) begin
      `CMP({cmd.start, cmd.code, cmd.addr}, {1'b1, c, a})
      cpu.xfer(1'b1, 8'h04, sz_w, 32'h0);
      cpu.xfer(1'b0, 8'h04, sz_w, 32'h0);
      `CMP(rdata, {c, a})
      @(posedge clk_sys_i) cmd_done_i <= 1'b1;
      @(posedge clk_sys_i) cmd_done_i <= 1'b0;
    end else begin
      // A pending violation must block the next launch
      cpu.st(8'h80);
      @(posedge clk_sys_i);
      #1;
      `CMP({flag, viol}, 2'b11)
      cpu.st(8'h10);
    end
    @(posedge clk_sys_i);
    #1;
    `CMP({flag, viol}, 2'b10)
  endtask

  task automatic region_protect_bits_wr(input logic [31:0] d, input logic [31:0] e);
    cpu.xfer(1'b1, 8'h10, sz_w, d);
    `CMP(bits, e)
    cpu.xfer(1'b0, 8'h10, sz_w, 32'h0);
    `CMP(rdata, e)
  endtask

  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    #200us;
    miscompares++;
    results();
  end

  initial begin
    reset_n_i = 1'b0;
    ce = 1'b1;
    special_mode_i = 1'b0;
    cfg_valid_i = 1'b0;
    cmd_done_i = 1'b0;
    flash_kb_i = 16'h0040;
    cfg_region_protect_bits_i = 32'h0;
    repeat (10) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i) cfg_valid_i <= 1'b1;
    cfg_region_protect_bits_i <= 32'hfe7fff7e;
    @(posedge clk_sys_i) cfg_valid_i <= 1'b0;
    cfg_region_protect_bits_i <= 32'h0;
    @(posedge clk_sys_i);
    #1;
    `CMP(bits, 32'hfe7fff7e)
    // Clock enable low must freeze the loaded protection
    @(posedge clk_sys_i) ce <= 1'b0;
    cpu.xfer(1'b1, 8'h10, sz_w, 32'h0);
    `CMP(bits, 32'hfe7fff7e)
    @(posedge clk_sys_i) ce <= 1'b1;
    region_protect_bits_wr(32'h0fffffff, 32'h0e7fff7e);
    @(posedge clk_sys_i) special_mode_i <= 1'b1;
    region_protect_bits_wr(32'hfffffffe, 32'hfffffffe);
    @(posedge clk_sys_i) special_mode_i <= 1'b0;
    cpu.xfer(1'b1, 8'h04, sz_w, 32'h06123456);
    cpu.xfer(1'b1, 8'h05, sz_h, 32'hffffffff);
    cpu.xfer(1'b0, 8'h04, sz_w, 32'h0);
    `CMP(rdata, 32'h06123456)
    launch(8'h06, 24'h0007fc, 1'b0);
    launch(8'h06, 24'h000800, 1'b1);
    launch(8'h09, 24'h00f800, 1'b1);
    launch(8'h08, 24'h000000, 1'b0);
    launch(8'h44, 24'h000000, 1'b0);
    @(posedge clk_sys_i) flash_kb_i <= 16'h0010;
    special_mode_i <= 1'b1;
    region_protect_bits_wr(32'h0000fffd, 32'h0000fffd);
    launch(8'h06, 24'h000400, 1'b0);
    launch(8'h06, 24'h000800, 1'b1);
    // Region 0 was unprotected above, so its bytes may be reprogrammed
    launch(8'h06, 24'h00000c, 1'b1);
    launch(8'h08, 24'h000000, 1'b0);
    region_protect_bits_wr(32'h0000ffff, 32'h0000ffff);
    launch(8'h08, 24'h000000, 1'b1);
    @(posedge clk_sys_i) flash_kb_i <= 16'h0008;
    region_protect_bits_wr(32'h000000ff, 32'h000000ff);
    launch(8'h08, 24'h000000, 1'b1);
    results();
  end
endmodule
